// ---- rtl/mit_pkg.sv ----
// Package: constants and carrier types for the instruction timing decoder
package mit_pkg;

    // Byte lengths and clock counts (single system clocks, no machine cycles)
    localparam logic [1:0] MIT_LEN_1 = 2'h1;
    localparam logic [1:0] MIT_LEN_2 = 2'h2;
    localparam logic [1:0] MIT_LEN_3 = 2'h3;
    localparam logic [3:0] MIT_CYC_1 = 4'h1;
    localparam logic [3:0] MIT_CYC_2 = 4'h2;
    localparam logic [3:0] MIT_CYC_3 = 4'h3;

    // Reset values
    localparam logic [7:0] MIT_OPC_RST = 8'h00;
    localparam logic [3:0] MIT_CNT_RST = 4'h0;

    // Opcode field positions
    localparam int MIT_OPC_HI_MSB = 7;
    localparam int MIT_OPC_HI_LSB = 4;

    // Opcode high nibbles of the covered groups
    localparam logic [3:0] MIT_HI_ADD                  = 4'h2;
    localparam logic [3:0] MIT_HI_ADD_WITH_CARRY       = 4'h3;
    localparam logic [3:0] MIT_HI_BITWISE_OR_OP        = 4'h4;
    localparam logic [3:0] MIT_HI_BITWISE_AND_OP       = 4'h5;
    localparam logic [3:0] MIT_HI_BITWISE_XOR_OP       = 4'h6;
    localparam logic [3:0] MIT_HI_MOVI                 = 4'h7;
    localparam logic [3:0] MIT_HI_MOVD                 = 4'h8;
    localparam logic [3:0] MIT_HI_SUBTRACT_WITH_BORROW = 4'h9;
    localparam logic [3:0] MIT_HI_MOVR                 = 4'ha;
    localparam logic [3:0] MIT_HI_MOVA                 = 4'he;
    localparam logic [3:0] MIT_HI_MOVS                 = 4'hf;

    // Single opcodes of the covered groups
    localparam logic [7:0] MIT_OP_RR_A               = 8'h03;
    localparam logic [7:0] MIT_OP_ROTATE_RIGHT_CARRY = 8'h13;
    localparam logic [7:0] MIT_OP_RL_A               = 8'h23;
    localparam logic [7:0] MIT_OP_ROTATE_LEFT_CARRY  = 8'h33;
    localparam logic [7:0] MIT_OP_CLR_A              = 8'he4;
    localparam logic [7:0] MIT_OP_CPL_A              = 8'hf4;
    localparam logic [7:0] MIT_OP_XRD_IND            = 8'he2;
    localparam logic [7:0] MIT_OP_XRD_DP             = 8'he0;
    localparam logic [7:0] MIT_OP_XWR_IND            = 8'hf2;
    localparam logic [7:0] MIT_OP_XWR_DP             = 8'hf0;

    // Flash window of the program space reached by the external-space move
    localparam logic [15:0] MIT_FLASH_LAST = 16'h1dff;

    // Decoded timing record
    typedef struct packed {
        logic       valid;
        logic       known;
        logic [1:0] length;
        logic [3:0] cycles;
    } mit_timing_type;

    // Target of an external-space move
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        to_flash;
        logic        to_aux_ram;
        logic        blocked;
        logic [15:0] addr;
    } mit_xmove_type;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        MIT_ST_IDLE = 3'b001,
        MIT_ST_EXEC = 3'b010,
        MIT_ST_DONE = 3'b100
    } mit_state_type;

endpackage

// ---- rtl/mit_lookup.sv ----
// Combinational opcode to length and clock-count table
`timescale 1ns/10ps
module mit_lookup (
    // Opcode in
    input  wire logic [7:0]              opcode,
    // Timing out
    output mit_pkg::mit_timing_type      timing
);
    import mit_pkg::*;

    logic [3:0] hi;
    logic [3:0] lo;

    assign hi = opcode[MIT_OPC_HI_MSB:MIT_OPC_HI_LSB];
    assign lo = opcode[3:0];

    // Low nibble: 8..f bank register, 6/7 indirect, 5 direct, 4 immediate
    always_comb begin
        timing        = '0;
        timing.valid  = 1'b1;
        case (hi)
            MIT_HI_ADD, MIT_HI_ADD_WITH_CARRY, MIT_HI_SUBTRACT_WITH_BORROW: begin
                if (lo[3]) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_1};
                end else if (lo[3:1] == 3'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_2};
                end else if (lo == 4'h5) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo == 4'h4) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end
            end
            MIT_HI_BITWISE_AND_OP, MIT_HI_BITWISE_OR_OP, MIT_HI_BITWISE_XOR_OP: begin
                if (lo[3]) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_1};
                end else if (lo[3:1] == 3'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_2};
                end else if (lo == 4'h5) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo == 4'h4) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo == 4'h2) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo == 4'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_3, MIT_CYC_3};
                end
            end
            MIT_HI_MOVI: begin
                if (lo[3] || lo[3:1] == 3'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo == 4'h5) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_3, MIT_CYC_3};
                end else if (lo == 4'h4) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end
            end
            MIT_HI_MOVD: begin
                if (lo[3]) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo[3:1] == 3'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end else if (lo == 4'h5) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_3, MIT_CYC_3};
                end
            end
            MIT_HI_MOVR: begin
                if (lo[3] || lo[3:1] == 3'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end
            end
            MIT_HI_MOVA, MIT_HI_MOVS: begin
                if (lo[3]) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_1};
                end else if (lo[3:1] == 3'h3) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_2};
                end else if (lo == 4'h5) begin
                    timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
                end
            end
            default: begin
                timing.valid = 1'b1;
            end
        endcase
        // Accumulator clear, complement and rotates
        if (opcode == MIT_OP_CLR_A || opcode == MIT_OP_CPL_A ||
            opcode == MIT_OP_RL_A  || opcode == MIT_OP_ROTATE_LEFT_CARRY ||
            opcode == MIT_OP_RR_A  || opcode == MIT_OP_ROTATE_RIGHT_CARRY) begin
            timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_1};
        end
        // Direct-to-accumulator move (hi e, lo 5) kept as two bytes
        if (opcode == 8'he5) begin
            timing = '{1'b1, 1'b1, MIT_LEN_2, MIT_CYC_2};
        end
        // External-space moves: one byte, three clocks
        if (opcode == MIT_OP_XRD_IND || opcode == 8'he3 ||
            opcode == MIT_OP_XWR_IND || opcode == 8'hf3 ||
            opcode == MIT_OP_XRD_DP || opcode == MIT_OP_XWR_DP) begin
            timing = '{1'b1, 1'b1, MIT_LEN_1, MIT_CYC_3};
        end
    end

endmodule // mit_lookup

// ---- rtl/mit_decoder.sv ----
// Instruction length, clock count and external-space move target decoder
`timescale 1ns/10ps
module mit_decoder (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    clk_en,
    // Opcode from fetch stage, same clock domain
    input  wire logic                    op_valid,
    input  wire logic [7:0]              opcode,
    // Timing to fetch and sequencing logic
    output mit_pkg::mit_timing_type      timing,
    output logic                         fetch_ready,
    output logic                         instr_done,
    // External-space move request
    input  wire logic [15:0]             xmove_addr,
    input  wire logic                    store_write_enable,
    input  wire logic                    flash_select,
    output mit_pkg::mit_xmove_type       xmove
);
    import mit_pkg::*;

    // All state of the decoder
    typedef struct packed {
        mit_state_type  state;
        mit_timing_type timing;
        mit_xmove_type  xmove;
        logic [3:0]     count;
        logic           done;
    } mit_regs_type;

    mit_regs_type   regs_r;
    mit_regs_type   regs_nxt;
    mit_timing_type lookup;
    logic           is_xmove;
    logic           is_write;

    // Table lookup kept combinational so timing is known in the accept cycle
    mit_lookup u_lookup (
        .opcode (opcode),
        .timing (lookup)
    );

    assign is_xmove = (opcode[7:5] == 3'h7) && (opcode[3:2] == 2'h0) && (opcode[1:0] != 2'h1);
    assign is_write = opcode[4];

    // Next-state logic
    always_comb begin
        regs_nxt      = regs_r;
        regs_nxt.done = 1'b0;
        case (regs_r.state)
            MIT_ST_IDLE, MIT_ST_DONE: begin
                regs_nxt.state = MIT_ST_IDLE;
                regs_nxt.xmove = '0;
                if (op_valid) begin
                    regs_nxt.timing = lookup;
                    regs_nxt.count  = lookup.cycles - MIT_CYC_1;
                    if (is_xmove) begin
                        // Only on-chip targets exist; no external bus is decoded
                        regs_nxt.xmove.valid      = 1'b1;
                        regs_nxt.xmove.write      = is_write;
                        regs_nxt.xmove.addr       = xmove_addr;
                        regs_nxt.xmove.to_flash   = flash_select;
                        regs_nxt.xmove.to_aux_ram = !flash_select;
                        // Flash write needs store enable and a mapped address
                        regs_nxt.xmove.blocked    = flash_select && is_write &&
                            (!store_write_enable || xmove_addr > MIT_FLASH_LAST);
                    end
                    if (lookup.cycles <= MIT_CYC_1) begin
                        regs_nxt.state = MIT_ST_DONE;
                        regs_nxt.done  = 1'b1;
                    end else begin
                        regs_nxt.state = MIT_ST_EXEC;
                    end
                end
            end
            MIT_ST_EXEC: begin
                // One clock per count step, no machine-cycle prescaler
                regs_nxt.count = regs_r.count - MIT_CYC_1;
                if (regs_r.count == MIT_CYC_1) begin
                    regs_nxt.state = MIT_ST_DONE;
                    regs_nxt.done  = 1'b1;
                end
            end
            default: begin
                regs_nxt.state = MIT_ST_IDLE;
            end
        endcase
    end

    // State register, frozen while clk_en is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regs_r <= '{MIT_ST_IDLE, '0, '0, MIT_CNT_RST, 1'b0};
        end else if (clk_en) begin
            regs_r <= regs_nxt;
        end
    end

    // Outputs
    assign timing      = regs_r.timing;
    assign xmove       = regs_r.xmove;
    assign instr_done  = regs_r.done;
    assign fetch_ready = (regs_r.state != MIT_ST_EXEC);

endmodule // mit_decoder

// ---- dv/mit_decoder_props.sv ----
// Port checker for the instruction timing decoder
`timescale 1ns/10ps
module mit_decoder_props (
    // Clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              clk_en,
    // Opcode side
    input wire logic              op_valid,
    input wire logic [7:0]        opcode,
    input wire logic              fetch_ready,
    input wire logic              instr_done,
    input mit_pkg::mit_timing_type timing,
    // External-space move side
    input wire logic [15:0]       xmove_addr,
    input wire logic              store_write_enable,
    input wire logic              flash_select,
    input mit_pkg::mit_xmove_type xmove
);
    import mit_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Accept strobe and opcode classes
    wire take  = clk_en && fetch_ready && op_valid;
    wire arlog = opcode[7:4] inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6};
    wire lgc   = opcode[7:4] inside {4'h4, 4'h5, 4'h6};
    wire xm    = opcode inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
    wire rot   = opcode inside {8'h03, 8'h13, 8'h23, 8'h33, 8'he4, 8'hf4};

    a_record_after_take: assert property (take |=> timing.valid)
        else $error("timing record not valid after accept");
    a_bank_one_clock: assert property (take && arlog && opcode[3] |=> instr_done
        && timing.length == MIT_LEN_1 && timing.cycles == MIT_CYC_1)
        else $error("bank register form not one byte one clock");
    a_indirect_two: assert property (take && arlog && opcode[3:1] == 3'h3 |=>
        timing.length == MIT_LEN_1 && timing.cycles == MIT_CYC_2)
        else $error("indirect form not one byte two clocks");
    a_direct_done: assert property ((take && arlog && opcode[3:0] == 4'h5) ##1 clk_en |->
        !instr_done ##1 instr_done)
        else $error("direct form done not after two clocks");
    a_triple_form: assert property (take && (opcode inside {8'h75, 8'h85} ||
        (lgc && opcode[3:0] == 4'h3)) |=> timing.length == MIT_LEN_3 && timing.cycles == MIT_CYC_3)
        else $error("three byte form wrong");
    a_accu_single: assert property (take && rot |=> timing.cycles == MIT_CYC_1)
        else $error("accumulator op not one clock");
    a_move_three: assert property (take && xm |=> timing.cycles == MIT_CYC_3 && xmove.valid)
        else $error("external move timing wrong");
    a_target_onchip: assert property (xmove.valid |-> xmove.to_flash ^ xmove.to_aux_ram)
        else $error("move target not one on-chip space");
    a_flash_guard: assert property (take && xm && opcode[4] && flash_select
        && !store_write_enable |=> xmove.blocked)
        else $error("flash write not blocked without enable");
    a_ready_on_done: assert property (instr_done |-> fetch_ready)
        else $error("not ready in done cycle");
    a_record_holds: assert property (!take |=> $stable(timing))
        else $error("timing record changed without accept");

    // Main scenarios reached
    c_take_move: cover property (take && xm);
    c_blocked: cover property (xmove.blocked);
    c_three: cover property (take && opcode == 8'h85);
    c_stalled: cover property (!clk_en && !fetch_ready);
endmodule // mit_decoder_props

// ---- dv/tb_mit_decoder.sv ----
// Self-checking bench for the instruction timing decoder
`timescale 1ns/10ps
module tb_mit_decoder;
    import mit_pkg::*;
    // Driven and observed ports
    logic           clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, op_valid = 1'b0;
    logic [7:0]     opcode = 8'h00;
    logic [15:0]    xmove_addr = 16'h0000, a;
    logic           store_write_enable = 1'b0, flash_select = 1'b0;
    logic           fetch_ready, instr_done;
    mit_timing_type timing;
    mit_xmove_type  xmove;
    logic [7:0]     op;
    logic [7:0]     xops [6] = '{8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
    int             bad_count = 0, checked = 0, stall_n = 0;

    always #20 clk = ~clk;

    mit_decoder i_mit_decoder (.clk(clk), .rstn(rstn), .clk_en(clk_en), .op_valid(op_valid),
        .opcode(opcode), .timing(timing), .fetch_ready(fetch_ready), .instr_done(instr_done),
        .xmove_addr(xmove_addr), .store_write_enable(store_write_enable),
        .flash_select(flash_select), .xmove(xmove));

    // Expected {known, length, cycles}; zero outside the covered rows
    function automatic logic [6:0] exp_of(input logic [7:0] o);
        logic [3:0] h;
        logic [3:0] l;
        h = o[7:4];
        l = o[3:0];
        if (o inside {8'h03, 8'h13, 8'h23, 8'h33, 8'he4, 8'hf4}) return {1'b1, MIT_LEN_1, MIT_CYC_1};
        if (o inside {xops}) return {1'b1, MIT_LEN_1, MIT_CYC_3};
        if (h inside {4'h2, 4'h3, 4'h9, 4'h4, 4'h5, 4'h6}) begin
            if (l[3]) return {1'b1, MIT_LEN_1, MIT_CYC_1};
            if (l[3:1] == 3'h3) return {1'b1, MIT_LEN_1, MIT_CYC_2};
            if (l[3:1] == 3'h2) return {1'b1, MIT_LEN_2, MIT_CYC_2};
            if (h inside {4'h4, 4'h5, 4'h6} && l == 4'h2) return {1'b1, MIT_LEN_2, MIT_CYC_2};
            if (h inside {4'h4, 4'h5, 4'h6} && l == 4'h3) return {1'b1, MIT_LEN_3, MIT_CYC_3};
        end
        if (h inside {4'h7, 4'h8} && l == 4'h5) return {1'b1, MIT_LEN_3, MIT_CYC_3};
        if ((h inside {4'h7, 4'h8, 4'ha} && l > 4'h5) || o == 8'hf5) return {1'b1, MIT_LEN_2, MIT_CYC_2};
        if (h inside {4'he, 4'hf} && l[3:1] == 3'h3) return {1'b1, MIT_LEN_1, MIT_CYC_2};
        if (h inside {4'he, 4'hf} && l[3]) return {1'b1, MIT_LEN_1, MIT_CYC_1};
        if (o inside {8'h74, 8'he5}) return {1'b1, MIT_LEN_2, MIT_CYC_2};
        return 7'h00;
    endfunction

    // Compare a record, then a count
    task automatic chk_rec(input logic [20:0] got, input logic [20:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic summarize;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One opcode: record, move target and clocks until done
    task automatic run_op(input logic [7:0] o, input logic [15:0] ad, input logic we, fs);
        logic [6:0]     e;
        mit_timing_type t;
        mit_xmove_type  x;
        int             n;
        e = exp_of(o);
        @(posedge clk);
        op_valid <= 1'b1;
        clk_en <= 1'b1;
        opcode <= o;
        xmove_addr <= ad;
        store_write_enable <= we;
        flash_select <= fs;
        @(posedge clk);
        op_valid <= 1'b0;
        // Freeze for stall_n clocks right after the accept
        clk_en <= (stall_n == 0);
        #1;
        t = timing;
        chk_rec({13'h0, t}, {13'h0, 1'b1, e});
        x = '0;
        if (o inside {xops}) x = '{1'b1, o[4], fs, !fs, o[4] && fs && (!we || ad > MIT_FLASH_LAST), ad};
        chk_rec(x.valid ? xmove : {xmove.valid, 20'h0}, x);
        n = 1;
        while (instr_done !== 1'b1 && n < 12) begin
            @(posedge clk);
            clk_en <= (n >= stall_n);
            #1;
            n++;
        end
        // Frozen clocks add to the count, except for ops already done at accept
        chk_cnt(4'(n), (e[3:0] <= 4'h1) ? 4'h1 : e[3:0] + 4'(stall_n));
        if (n >= 12) summarize();
    endtask

    initial begin
        void'($urandom(68));
        repeat (10) @(posedge clk);
        #1;
        chk_rec({13'h0, timing}, 21'h0); // Idle record in reset
        chk_rec(xmove, 21'h0); // No target in reset
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        // Every covered opcode once
        for (int i = 0; i < 256; i++)
            if (exp_of(8'(i)) != 7'h00) run_op(8'(i), 16'h0000, 1'b0, 1'b0);
        run_op(8'ha4, 16'h0000, 1'b0, 1'b0); // Outside the groups
        run_op(8'h84, 16'h0000, 1'b0, 1'b0); // Outside the groups
        // Move targets, enables and flash boundary
        foreach (xops[j])
            for (int k = 0; k < 16; k++) begin
                a = (k[1:0] == 0) ? MIT_FLASH_LAST : (k[1:0] == 1) ? MIT_FLASH_LAST + 16'h0001
                    : 16'($urandom) & MIT_FLASH_LAST;
                if (k[1:0] != 1 || (xops[j][4] && k[2]))
                    run_op(xops[j], a, k[3], k[2]);
            end
        // Random mix of covered opcodes with clock-enable stalls
        for (int r = 0; r < 300; r++) begin
            op = 8'($urandom);
            stall_n = $urandom % 3;
            if (exp_of(op) != 7'h00)
                run_op(op, 16'($urandom) & MIT_FLASH_LAST, 1'($urandom), 1'($urandom));
        end
        // Reset in mid-run, then decode resumes
        stall_n = 0;
        @(posedge clk);
        rstn <= 1'b0;
        clk_en <= 1'b1;
        @(posedge clk);
        #1;
        chk_rec({13'h0, timing}, 21'h0); // Record cleared
        chk_cnt({3'h0, fetch_ready}, 4'h1); // Ready in reset
        @(posedge clk);
        rstn <= 1'b1;
        run_op(8'h85, 16'h0000, 1'b0, 1'b0); // Copy after reset
        summarize();
    end
endmodule // tb_mit_decoder

bind mit_decoder mit_decoder_props i_mit_decoder_props (.clk(clk), .rstn(rstn), .clk_en(clk_en),
    .op_valid(op_valid), .opcode(opcode), .fetch_ready(fetch_ready), .instr_done(instr_done),
    .timing(timing), .xmove_addr(xmove_addr), .store_write_enable(store_write_enable),
    .flash_select(flash_select), .xmove(xmove));
